// *** dv/ppp_printer_model.sv ***
`timescale 1ns/1ns

// ****************************************
// Printer side of the port
// ****************************************
module ppp_printer_model (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [7:0] pd_out,
   input wire logic [7:0] pd_oe,
   output logic [7:0] pd_lvl,
   input wire logic [3:0] od_oe,
   input wire logic [3:0] od_out,
   output logic [3:0] od_lvl,
   output logic ack_n,
   output logic busy,
   output logic fault_n,
   output logic sel,
   output logic pe
);
   logic [7:0] pd_val = 8'h00;
   logic pd_drv = 1'b0;
   logic [3:0] pull = 4'h0;
   logic [7:0] junk_ff;

   initial begin
      {fault_n, sel, pe, busy} = 4'b1001;
      ack_n = 1'b1;
   end

   // Released bus flips each cycle so stale data never reads as valid
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         junk_ff <= 8'h5a;
      end else begin
         junk_ff <= ~junk_ff;
      end
   end

   assign pd_lvl = (pd_oe & pd_out) | (~pd_oe & (pd_drv ? pd_val : junk_ff));
   // Pull-up lines: low if either side pulls
   assign od_lvl = ~((od_oe & ~od_out) | pull);

   task automatic set_in(input logic [3:0] v);
      {fault_n, sel, pe, busy} <= v;
   endtask

   task automatic set_ack(input logic v);
      ack_n <= v;
   endtask

   task automatic drive(input logic en, input logic [7:0] v);
      pd_drv <= en;
      pd_val <= v;
   endtask

   task automatic set_pull(input logic [3:0] v);
      pull <= v;
   endtask
endmodule // ppp_printer_model

// *** dv/test_printer_parallel_port.sv ***
`timescale 1ns/1ns
`include "ppp_defs.svh"

module test_printer_parallel_port;
   // ****************************************
   // Signals
   // ****************************************
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic dsel = 1'b0, lmode = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, irq_out, irq_oe;
   wire [7:0] pd_in, pd_out, pd_oe;
   wire [3:0] od_oe, od_out, od_lvl;
   wire ack_n, busy, fault_n, sel_in, pe_in;
   int mismatches = 0, n_tests = 0, cycles = 0;
   logic [31:0] rd;
   logic err;

   ppp_port uut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .parallel_data_pins_in(pd_in), .parallel_data_pins_out(pd_out), .parallel_data_pins_oe(pd_oe),
      .ack_n(ack_n), .busy(busy), .fault_n(fault_n), .selected_input(sel_in), .media_empty_input(pe_in),
      .dir_pin_select(dsel), .irq_latch_mode(lmode), .strobe_n_in(od_lvl[0]), .strobe_n_out(od_out[0]),
      .strobe_n_oe(od_oe[0]), .auto_linefeed_line_in(od_lvl[1]), .auto_linefeed_line_out(od_out[1]),
      .auto_linefeed_line_oe(od_oe[1]), .select_request_out_in(od_lvl[2]),
      .select_request_out_out(od_out[2]), .select_request_out_oe(od_oe[2]), .dev_reset_in(od_lvl[3]),
      .dev_reset_out(od_out[3]), .dev_reset_oe(od_oe[3]),
      .port_irq_out_out(irq_out), .port_irq_out_oe(irq_oe));

   ppp_printer_model prn (.sys_clk(sys_clk), .arst_n(arst_n), .pd_out(pd_out), .pd_oe(pd_oe),
      .pd_lvl(pd_in), .od_oe(od_oe), .od_out(od_out), .od_lvl(od_lvl), .ack_n(ack_n), .busy(busy),
      .fault_n(fault_n),
      .sel(sel_in), .pe(pe_in));

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   // Whole run needs a few hundred cycles; far above that means a hang
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         complete_run();
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask

   // Request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk8(rd[7:0], exp);
      chk8(rd[15:8] | rd[23:16] | rd[31:24], 8'h00);
      chk1(err, 1'b0);
   endtask

   // Pin inputs pass a synchroniser, so allow several cycles
   task automatic settle();
      repeat (6) @(posedge sys_clk);
   endtask

   task automatic pulse_ack();
      prn.set_ack(1'b0);
      settle();
      prn.set_ack(1'b1);
      settle();
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      settle();
      chk8(pd_oe, 8'hff);
      chk8(pd_out, 8'h00);
      chk8({4'h0, od_lvl}, 8'h07);
      chk1(irq_oe, 1'b0);
      rreg(`PPP_OFF_STATUS, 8'hcf);
      rreg(`PPP_OFF_CTRL, 8'he0);
      rreg(`PPP_OFF_DIR, 8'h00);
      $display("test reset done");

      wreg(`PPP_OFF_DATA, 8'ha5);
      settle();
      chk8(pd_out, 8'ha5);
      pstrb <= 4'h0;
      wreg(`PPP_OFF_DATA, 8'h3c);
      pstrb <= 4'hf;
      rreg(`PPP_OFF_DATA, 8'ha5);
      $display("test data latch done");

      wreg(`PPP_OFF_DIR, 8'haa);
      prn.drive(1'b1, 8'h69);
      settle();
      chk8(pd_oe, 8'h00);
      rreg(`PPP_OFF_DATA, 8'h69);
      wreg(`PPP_OFF_DIR, 8'h12);
      settle();
      chk8(pd_oe, 8'h00);
      rreg(`PPP_OFF_DIR, 8'h12);
      wreg(`PPP_OFF_DIR, 8'h55);
      settle();
      chk8(pd_oe, 8'hff);
      dsel <= 1'b1;
      settle();
      wreg(`PPP_OFF_DIR, 8'haa);
      settle();
      chk8(pd_oe, 8'hff);
      wreg(`PPP_OFF_CTRL, 8'h20);
      settle();
      chk8(pd_oe, 8'h00);
      rreg(`PPP_OFF_CTRL, 8'he0);
      wreg(`PPP_OFF_CTRL, 8'h00);
      settle();
      chk8(pd_oe, 8'hff);
      wreg(`PPP_OFF_DIR, 8'h55);
      dsel <= 1'b0;
      prn.drive(1'b0, 8'h00);
      $display("test direction done");

      for (int i = 0; i < 5; i++) begin
         wreg(`PPP_OFF_CTRL, 8'h01 << i);
         settle();
         chk8({4'h0, od_lvl}, {4'h0, (i == 2), ~(i == 3), ~(i == 1), ~(i == 0)});
         chk1(irq_oe, (i == 4));
         rreg(`PPP_OFF_CTRL, 8'he0 | (8'h01 << i));
      end
      wreg(`PPP_OFF_CTRL, 8'h00);
      prn.set_pull(4'h1);
      settle();
      rreg(`PPP_OFF_CTRL, 8'he1);
      prn.set_pull(4'h0);
      $display("test control lines done");

      for (int k = 0; k < 16; k += 5) begin
         prn.set_in(k[3:0]);
         settle();
         rreg(`PPP_OFF_STATUS, {k[0], 1'b1, k[1], k[2], k[3], 3'b111});
      end
      prn.set_in(4'b1001);
      $display("test status inputs done");

      wreg(`PPP_OFF_CTRL, 8'h10);
      prn.set_ack(1'b0);
      settle();
      chk1(irq_out, 1'b0);
      chk1(irq_oe, 1'b1);
      rreg(`PPP_OFF_STATUS, 8'h8b);
      prn.set_ack(1'b1);
      settle();
      rreg(`PPP_OFF_STATUS, 8'hcf);
      chk1(irq_out, 1'b1);
      lmode <= 1'b1;
      settle();
      pulse_ack();
      chk1(irq_out, 1'b0);
      rreg(`PPP_OFF_STATUS, 8'hcb);
      rreg(`PPP_OFF_STATUS, 8'hcf);
      chk1(irq_out, 1'b1);
      wreg(`PPP_OFF_CTRL, 8'h00);
      pulse_ack();
      chk1(irq_oe, 1'b0);
      rreg(`PPP_OFF_STATUS, 8'hcb);
      $display("test interrupt done");

      apb(1'b0, 8'h10, 8'h00);
      chk1(err, 1'b1);
      chk8(rd[7:0], 8'h00);
      apb(1'b1, 8'h14, 8'hff);
      chk1(err, 1'b1);
      $display("test unmapped done");
      complete_run();
   end
endmodule // test_printer_parallel_port

// *** verilog/ppp_defs.svh ***
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PPP_OFF_DATA 8'h00
`define PPP_OFF_STATUS 8'h04
`define PPP_OFF_CTRL 8'h08
`define PPP_OFF_DIR 8'h0c

// ****************************************
// Reset values
// ****************************************
`define PPP_DATA_RST 8'h00
`define PPP_DIR_RST 8'h00
`define PPP_CTRL_RST 8'hc0
`define PPP_PINS_RST 19'h0070e

// ****************************************
// Direction codes
// ****************************************
`define PPP_DIR_CODE_OUT 8'h55
`define PPP_DIR_CODE_IN 8'haa

// ****************************************
// Control field positions
// ****************************************
`define PPP_CTRL_STROBE 0
`define PPP_CTRL_AFD 1
`define PPP_CTRL_INIT 2
`define PPP_CTRL_SLIN 3
`define PPP_CTRL_IRQ_EN 4
`define PPP_CTRL_DIR_IN 5

// ****************************************
// Status field positions
// ****************************************
`define PPP_ST_PEND_N 2
`define PPP_ST_FAULT 3
`define PPP_ST_SEL 4
`define PPP_ST_PE 5
`define PPP_ST_ACK 6
`define PPP_ST_BUSY 7

`endif

// *** verilog/ppp_irq.sv ***
`timescale 1ns/1ns

module ppp_irq (
   input wire logic sys_clk,
   input wire logic arst_n,
   ppp_irq_if.irq bus
);

   logic ack_d_ff;
   logic lat_n_ff;
   logic ack_fall;

   assign ack_fall = ack_d_ff & ~bus.ack_lvl;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_d_ff <= 1'b1;
      end else begin
         ack_d_ff <= bus.ack_lvl;
      end
   end

   // ****************************************
   // Latched pending flag
   // ****************************************
   // A fall in the clearing cycle wins so no acknowledge is lost
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lat_n_ff <= 1'b1;
      end else if (!bus.latch_mode) begin
         lat_n_ff <= 1'b1;
      end else if (ack_fall) begin
         lat_n_ff <= 1'b0;
      end else if (bus.rd_clr) begin
         lat_n_ff <= 1'b1;
      end
   end

   assign bus.pend_n = bus.latch_mode ? lat_n_ff : bus.ack_lvl;

   latch_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (bus.latch_mode && !lat_n_ff && !bus.rd_clr) ##1 bus.latch_mode |-> !bus.pend_n)
      else $error("latched pending flag dropped without a status read");

   latch_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (bus.latch_mode && ack_fall) ##1 bus.latch_mode |-> !bus.pend_n)
      else $error("acknowledge fall did not latch a pending flag");

endmodule // ppp_irq

// *** verilog/ppp_irq_if.sv ***
`timescale 1ns/1ns

interface ppp_irq_if;
   logic ack_lvl;
   logic latch_mode;
   logic rd_clr;
   logic pend_n;

   modport core (
      output ack_lvl,
      output latch_mode,
      output rd_clr,
      input pend_n
   );

   modport irq (
      input ack_lvl,
      input latch_mode,
      input rd_clr,
      output pend_n
   );
endinterface

// *** verilog/ppp_pkg.sv ***
package ppp_pkg;

   typedef enum logic [2:0] {
      PPP_REG_DATA,
      PPP_REG_STATUS,
      PPP_REG_CTRL,
      PPP_REG_DIR,
      PPP_REG_NONE
   } ppp_reg_e;

   typedef enum logic {
      PPP_APB_IDLE,
      PPP_APB_ACCESS
   } ppp_apb_e;

endpackage

// *** verilog/ppp_port.sv ***
`timescale 1ns/1ns
`include "ppp_defs.svh"

// Function
// - Data write drives latch onto data pins
// - Pin low: code 55 out, aa in
// - Pin high: control bit 5 sets direction
// - Unused status, readback, control bits read one
// - Track mode: pending bit follows acknowledge
// - Latch mode: pending held until status read
// - Status bits 3-7 show input levels
// - Control bit 0 drives strobe low
// - Control bit 1 drives linefeed low
// - Control bit 2 drives reset line level
// - Control bit 3 drives select request low
// - Control bit 4 enables interrupt output
// - Readback shows inverted handshake pins, reset level
// - Readback bit 4 returns interrupt enable
// - Readback hides data direction control bit
// - Reset clears direction code and control
// - Reset: data out low, reset line low, other lines high
module ppp_port
   import ppp_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] parallel_data_pins_in,
   output logic [7:0] parallel_data_pins_out,
   output logic [7:0] parallel_data_pins_oe,
   input wire logic ack_n,
   input wire logic busy,
   input wire logic fault_n,
   input wire logic selected_input,
   input wire logic media_empty_input,
   input wire logic dir_pin_select,
   input wire logic irq_latch_mode,
   input wire logic strobe_n_in,
   output logic strobe_n_out,
   output logic strobe_n_oe,
   input wire logic auto_linefeed_line_in,
   output logic auto_linefeed_line_out,
   output logic auto_linefeed_line_oe,
   input wire logic select_request_out_in,
   output logic select_request_out_out,
   output logic select_request_out_oe,
   input wire logic dev_reset_in,
   output logic dev_reset_out,
   output logic dev_reset_oe,
   output logic port_irq_out_out,
   output logic port_irq_out_oe
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [18:0] pins_raw;
   logic [18:0] pins_q;
   logic [7:0] pd_q;
   logic ack_q;
   logic busy_q;
   logic fault_q;
   logic sel_q;
   logic pe_q;
   logic dsel_q;
   logic lmode_q;
   logic strobe_q;
   logic afd_q;
   logic slin_q;
   logic init_q;

   assign pins_raw = {parallel_data_pins_in, ack_n, busy, fault_n, selected_input, media_empty_input,
                      dir_pin_select, irq_latch_mode, strobe_n_in, auto_linefeed_line_in,
                      select_request_out_in, dev_reset_in};

   ppp_sync #(
      .W(19),
      .RST(`PPP_PINS_RST)
   ) u_sync (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .d(pins_raw),
      .q(pins_q)
   );

   assign {pd_q, ack_q, busy_q, fault_q, sel_q, pe_q, dsel_q, lmode_q, strobe_q, afd_q, slin_q, init_q} = pins_q;

   // ****************************************
   // Acknowledge interrupt flag
   // ****************************************
   ppp_irq_if irq_if ();
   logic rd_clr;

   assign irq_if.ack_lvl = ack_q;
   assign irq_if.latch_mode = lmode_q;
   assign irq_if.rd_clr = rd_clr;

   ppp_irq u_irq (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .bus(irq_if)
   );

   // ****************************************
   // Address decode
   // ****************************************
   function automatic ppp_reg_e decode(input logic [ADDR_W-1:0] a);
      ppp_reg_e r;
      r = PPP_REG_NONE;
      if (a == ADDR_W'(`PPP_OFF_DATA)) begin
         r = PPP_REG_DATA;
      end else if (a == ADDR_W'(`PPP_OFF_STATUS)) begin
         r = PPP_REG_STATUS;
      end else if (a == ADDR_W'(`PPP_OFF_CTRL)) begin
         r = PPP_REG_CTRL;
      end else if (a == ADDR_W'(`PPP_OFF_DIR)) begin
         r = PPP_REG_DIR;
      end
      return r;
   endfunction

   ppp_apb_e state_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   ppp_reg_e sel_reg;
   logic setup;
   logic access;
   logic wr_en;

   assign sel_reg = decode(paddr);
   assign setup = psel && !penable && (state_ff == PPP_APB_IDLE);
   assign access = psel && penable && pready_ff;
   assign wr_en = access && pwrite && pstrb[0];

   // ****************************************
   // Software registers
   // ****************************************
   logic [7:0] data_ff;
   logic [7:0] dir_code_ff;
   logic direction_code_register_in_ff;
   logic [7:0] ctrl_ff;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         data_ff <= `PPP_DATA_RST;
      end else if (wr_en && sel_reg == PPP_REG_DATA) begin
         data_ff <= pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_code_ff <= `PPP_DIR_RST;
         direction_code_register_in_ff <= 1'b0;
      end else if (wr_en && sel_reg == PPP_REG_DIR) begin
         dir_code_ff <= pwdata[7:0];
         // Other codes leave the mode as it was
         if (pwdata[7:0] == `PPP_DIR_CODE_OUT) begin
            direction_code_register_in_ff <= 1'b0;
         end else if (pwdata[7:0] == `PPP_DIR_CODE_IN) begin
            direction_code_register_in_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_ff <= `PPP_CTRL_RST;
      end else if (wr_en && sel_reg == PPP_REG_CTRL) begin
         ctrl_ff <= {2'b11, pwdata[5:0]};
      end
   end

   // ****************************************
   // Read views
   // ****************************************
   logic [7:0] status_view;
   logic [7:0] readback_view;
   logic nxt_dir_in;
   logic dir_in_ff;

   function automatic logic direction_code_register_dir_in_q();
      return dir_in_ff;
   endfunction

   assign status_view = {busy_q, ack_q, pe_q, sel_q, fault_q, irq_if.pend_n, 2'b11};
   assign readback_view = {3'b111, ctrl_ff[`PPP_CTRL_IRQ_EN], ~slin_q, init_q, ~afd_q, ~strobe_q};
   assign nxt_dir_in = dsel_q ? ctrl_ff[`PPP_CTRL_DIR_IN] : direction_code_register_in_ff;

   // Clear only if the reader saw the pending flag, so a later fall is kept
   assign rd_clr = access && !pwrite && sel_reg == PPP_REG_STATUS && !prdata_ff[`PPP_ST_PEND_N];

   // ****************************************
   // APB slave, one wait-free access phase
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= PPP_APB_IDLE;
         pready_ff <= 1'b0;
      end else begin
         case (state_ff)
            PPP_APB_IDLE: begin
               if (setup) begin
                  state_ff <= PPP_APB_ACCESS;
                  pready_ff <= 1'b1;
               end
            end
            PPP_APB_ACCESS: begin
               state_ff <= PPP_APB_IDLE;
               pready_ff <= 1'b0;
            end
            default: begin
               state_ff <= PPP_APB_IDLE;
               pready_ff <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end else if (setup) begin
         pslverr_ff <= (sel_reg == PPP_REG_NONE);
         prdata_ff <= '0;
         if (!pwrite) begin
            case (sel_reg)
               PPP_REG_DATA: prdata_ff <= {24'h000000, direction_code_register_dir_in_q() ? pd_q : data_ff};
               PPP_REG_STATUS: prdata_ff <= {24'h000000, status_view};
               PPP_REG_CTRL: prdata_ff <= {24'h000000, readback_view};
               PPP_REG_DIR: prdata_ff <= {24'h000000, dir_code_ff};
               default: prdata_ff <= '0;
            endcase
         end
      end else if (!psel) begin
         pslverr_ff <= 1'b0;
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   logic [7:0] pd_oe_ff;
   logic strobe_oe_ff;
   logic afd_oe_ff;
   logic slin_oe_ff;
   logic init_oe_ff;
   logic irq_out_ff;
   logic irq_oe_ff;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_in_ff <= 1'b0;
         pd_oe_ff <= 8'hff;
      end else begin
         dir_in_ff <= nxt_dir_in;
         pd_oe_ff <= {8{~nxt_dir_in}};
      end
   end

   // Open drain lines only ever pull low; release lets the pull-up win
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         strobe_oe_ff <= 1'b0;
         afd_oe_ff <= 1'b0;
         slin_oe_ff <= 1'b0;
         init_oe_ff <= 1'b1;
      end else begin
         strobe_oe_ff <= ctrl_ff[`PPP_CTRL_STROBE];
         afd_oe_ff <= ctrl_ff[`PPP_CTRL_AFD];
         slin_oe_ff <= ctrl_ff[`PPP_CTRL_SLIN];
         init_oe_ff <= ~ctrl_ff[`PPP_CTRL_INIT];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_oe_ff <= 1'b0;
         irq_out_ff <= 1'b1;
      end else begin
         irq_oe_ff <= ctrl_ff[`PPP_CTRL_IRQ_EN];
         irq_out_ff <= irq_if.pend_n | ~ctrl_ff[`PPP_CTRL_IRQ_EN];
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign parallel_data_pins_out = data_ff;
   assign parallel_data_pins_oe = pd_oe_ff;
   assign strobe_n_out = 1'b0;
   assign strobe_n_oe = strobe_oe_ff;
   assign auto_linefeed_line_out = 1'b0;
   assign auto_linefeed_line_oe = afd_oe_ff;
   assign select_request_out_out = 1'b0;
   assign select_request_out_oe = slin_oe_ff;
   assign dev_reset_out = 1'b0;
   assign dev_reset_oe = init_oe_ff;
   assign port_irq_out_out = irq_out_ff;
   assign port_irq_out_oe = irq_oe_ff;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   data_write_a: assert property ((wr_en && sel_reg == PPP_REG_DATA)
      |=> parallel_data_pins_out == $past(pwdata[7:0]))
      else $error("data write did not reach data pins");

   code_out_a: assert property ((wr_en && sel_reg == PPP_REG_DIR && pwdata[7:0] == 8'h55 && !dsel_q)
      ##1 !dsel_q |=> parallel_data_pins_oe == 8'hff)
      else $error("code 55 did not select output mode");

   code_in_a: assert property ((wr_en && sel_reg == PPP_REG_DIR && pwdata[7:0] == 8'haa && !dsel_q)
      ##1 !dsel_q |=> parallel_data_pins_oe == 8'h00)
      else $error("code aa did not select input mode");

   ctrl_dir_a: assert property ((dsel_q && $stable(dsel_q) && $stable(ctrl_ff[5]))
      |=> parallel_data_pins_oe == {8{~$past(ctrl_ff[5])}})
      else $error("control bit 5 did not set direction");

   unused_ones_a: assert property ((pready && !pwrite && sel_reg == PPP_REG_STATUS)
      |-> prdata[1:0] == 2'b11)
      else $error("unused status bits not one");

   readback_map_a: assert property ((pready && !pwrite && sel_reg == PPP_REG_CTRL)
      |-> prdata[7:4] == {3'b111, $past(ctrl_ff[4])})
      else $error("readback high bits wrong");

   track_ack_a: assert property ((pready && !pwrite && sel_reg == PPP_REG_STATUS && !lmode_q)
      |-> prdata[2] == prdata[6])
      else $error("tracking pending bit differs from acknowledge");

   strobe_ctrl_a: assert property ((wr_en && sel_reg == PPP_REG_CTRL)
      |=> ##1 strobe_n_oe == $past(pwdata[0], 2))
      else $error("strobe drive does not follow control bit 0");

   irq_gate_a: assert property ((port_irq_out_oe && !port_irq_out_out)
      |-> $past(ctrl_ff[4] && !irq_if.pend_n))
      else $error("interrupt asserted without pending and enable");

   wr_cov: cover property (wr_en && sel_reg == PPP_REG_DATA);
   rd_clr_cov: cover property (rd_clr);
   irq_cov: cover property (port_irq_out_oe && !port_irq_out_out);
   err_cov: cover property (pready && pslverr);

endmodule // ppp_port

// *** verilog/ppp_sync.sv ***
`timescale 1ns/1ns

module ppp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_ff <= RST;
         s2_ff <= RST;
         s3_ff <= RST;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // ****************************************
   // Accept a bit only when stages agree
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q_ff <= RST;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               q_ff[i] <= s3_ff[i];
            end
         end
      end
   end

   assign q = q_ff;

endmodule // ppp_sync
